/* File: inc/gpg_pkg.sv */
// Purpose: constants and types for the general-purpose port group
// Assumes: byte-wide register port, 8 pins per group
// Notes:   offsets are byte addresses within the group
package gpg_pkg;
    localparam int unsigned PINS = 8;
    localparam int unsigned AW   = 5;
    // register offsets
    localparam logic [4:0] OFF_DIR       = 5'h00;
    localparam logic [4:0] OFF_DIR_SET   = 5'h01;
    localparam logic [4:0] OFF_DIR_CLR   = 5'h02;
    localparam logic [4:0] OFF_DIR_TGL   = 5'h03;
    localparam logic [4:0] OFF_OUT       = 5'h04;
    localparam logic [4:0] OFF_OUT_SET   = 5'h05;
    localparam logic [4:0] OFF_OUT_CLR   = 5'h06;
    localparam logic [4:0] OFF_OUT_TGL   = 5'h07;
    localparam logic [4:0] OFF_LEVEL     = 5'h08;
    localparam logic [4:0] OFF_FLAGS     = 5'h09;
    localparam logic [4:0] OFF_GRP_CTRL  = 5'h0a;
    localparam logic [4:0] OFF_PIN_CTRL  = 5'h10;
    // fast alias offsets
    localparam logic [1:0] FA_DIR   = 2'h0;
    localparam logic [1:0] FA_OUT   = 2'h1;
    localparam logic [1:0] FA_LEVEL = 2'h2;
    localparam logic [1:0] FA_FLAGS = 2'h3;
    // pin control fields
    localparam int unsigned PC_INV_BIT  = 7;
    localparam int unsigned PC_PULL_BIT = 3;
    localparam logic [7:0]  PC_MASK     = 8'h8f;
    localparam logic [7:0]  RESET_BYTE  = 8'h00;
    localparam int unsigned DEAD_CYCLES = 3;
    // sense configuration encodings
    typedef enum logic [2:0] {
        SENSE_OFF     = 3'h0,
        SENSE_BOTH    = 3'h1,
        SENSE_RISE    = 3'h2,
        SENSE_FALL    = 3'h3,
        SENSE_NOBUF   = 3'h4,
        SENSE_LOW     = 3'h5
    } gpg_sense_t;
    typedef struct packed {
        logic        inv;
        logic [2:0]  rsvd;
        logic        pull;
        logic [2:0]  sense;
    } gpg_pin_ctrl_t;
    // register port request
    typedef struct packed {
        logic          wr;
        logic          rd;
        logic [4:0]    addr;
        logic [7:0]    wdata;
    } gpg_req_t;
endpackage

/* File: src/gpg_pin_sense.sv */
// Purpose: per-pin synchroniser, sense detection and dead time
// Assumes: pin level already inverted when polarity inversion is on
// Notes:   three flops; a change counts once stages two and three agree
`timescale 1ns/1ps
module gpg_pin_sense (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // pin side
    input  wire logic       pin_lvl,
    input  wire logic       buf_en,
    input  wire logic [2:0] sense,
    // results
    output logic            level,
    output logic            hit
);
    logic [2:0] sync_q;
    logic       level_q;
    logic [1:0] dead_q;
    logic       rise;
    logic       fall;
    logic       cond;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync_q <= 3'h0;
        end else if (buf_en) begin
            sync_q <= {sync_q[1:0], pin_lvl};
        end
    end

    // level follows only when stages two and three agree
    wire agree = (sync_q[2] == sync_q[1]);
    wire lvl_d = agree ? sync_q[2] : level_q;
    assign rise  = lvl_d & ~level_q;
    assign fall  = ~lvl_d & level_q;
    assign level = level_q;

    always_comb begin
        case (gpg_pkg::gpg_sense_t'(sense))
            gpg_pkg::SENSE_BOTH: cond = rise | fall;
            gpg_pkg::SENSE_RISE: cond = rise;
            gpg_pkg::SENSE_FALL: cond = fall;
            gpg_pkg::SENSE_LOW:  cond = ~lvl_d;
            default:             cond = 1'b0;
        endcase
    end

    assign hit = cond & buf_en & (dead_q == 2'h0);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            level_q <= 1'b0;
            dead_q  <= 2'h0;
        end else begin
            level_q <= buf_en ? lvl_d : level_q;
            if (hit) begin
                dead_q <= 2'(gpg_pkg::DEAD_CYCLES);
            end else if (dead_q != 2'h0) begin
                dead_q <= dead_q - 2'h1;
            end
        end
    end
endmodule

/* File: src/gpg_port_group.sv */
// Purpose: one general-purpose port group of up to eight pins
// Assumes: byte register port with one-cycle write strobe, fast alias port
// Notes:   pins are five signals each; override comes from routing logic
`timescale 1ns/1ps
module gpg_port_group #(
    parameter int unsigned N = gpg_pkg::PINS
) (
    // clock and reset
    input  wire logic            ref_clk,
    input  wire logic            rst,
    // register port
    input  wire gpg_pkg::gpg_req_t req,
    output logic [7:0]           rdata,
    // fast alias port
    input  wire logic            fa_wr,
    input  wire logic            fa_rd,
    input  wire logic [1:0]      fa_addr,
    input  wire logic [7:0]      fa_wdata,
    output logic [7:0]           fa_rdata,
    // pins
    input  wire logic [N-1:0]    pin_i,
    output logic [N-1:0]         pin_o,
    output logic [N-1:0]         pin_oe,
    output logic [N-1:0]         pin_pull,
    output logic [N-1:0]         pin_buf_en,
    output logic                 slew_limit,
    // peripheral override
    input  wire logic [N-1:0]    ovr_en,
    input  wire logic [N-1:0]    ovr_oe,
    input  wire logic [N-1:0]    ovr_o,
    // events, interrupt and wake
    output logic [N-1:0]         pin_event,
    output logic                 irq,
    output logic                 wake
);
    if (N < 1 || N > gpg_pkg::PINS) begin : g_chk
        $error("pin count must be 1 to 8");
    end

    function automatic logic [N-1:0] apply_bits(input logic [N-1:0] cur,
                                                 input logic [1:0] op,
                                                 input logic [N-1:0] m);
        case (op)
            2'h1:    apply_bits = cur | m;
            2'h2:    apply_bits = cur & ~m;
            2'h3:    apply_bits = cur ^ m;
            default: apply_bits = m;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic [N-1:0]   dir_q;
    logic [N-1:0]   out_q;
    logic [N-1:0]   flag_q;
    logic           slew_q;
    logic [7:0]     pctl_q [N];
    logic [N-1:0]   lvl;
    logic [N-1:0]   hit;
    logic [N-1:0]   inv;
    logic [N-1:0]   buf_on;
    logic [N-1:0]   irq_en;

    wire [N-1:0] wbits = req.wdata[N-1:0];
    wire [N-1:0] fbits = fa_wdata[N-1:0];
    wire reg_dir   = req.wr && (req.addr >= gpg_pkg::OFF_DIR)
                            && (req.addr <= gpg_pkg::OFF_DIR_TGL);
    wire reg_out   = req.wr && (req.addr >= gpg_pkg::OFF_OUT)
                            && (req.addr <= gpg_pkg::OFF_OUT_TGL);
    wire reg_lvl   = req.wr && (req.addr == gpg_pkg::OFF_LEVEL);
    wire reg_flag  = req.wr && (req.addr == gpg_pkg::OFF_FLAGS);
    wire reg_slew  = req.wr && (req.addr == gpg_pkg::OFF_GRP_CTRL);
    wire fa_dir    = fa_wr && (fa_addr == gpg_pkg::FA_DIR);
    wire fa_out    = fa_wr && (fa_addr == gpg_pkg::FA_OUT);
    wire fa_lvl    = fa_wr && (fa_addr == gpg_pkg::FA_LEVEL);
    wire fa_flag   = fa_wr && (fa_addr == gpg_pkg::FA_FLAGS);
    wire [1:0] op  = req.addr[1:0];

    // direction next value: regular port first, then alias
    wire [N-1:0] dir_a = reg_dir ? apply_bits(dir_q, op, wbits) : dir_q;
    wire [N-1:0] dir_d = fa_dir ? fbits : dir_a;
    // drive next value
    wire [N-1:0] out_a = reg_out ? apply_bits(out_q, op, wbits)
                       : reg_lvl ? (out_q ^ wbits) : out_q;
    wire [N-1:0] out_d = fa_out ? fbits : (fa_lvl ? (out_a ^ fbits) : out_a);
    // flags: hardware set wins over the clear
    wire [N-1:0] clr   = (reg_flag ? wbits : '0) | (fa_flag ? fbits : '0);
    wire [N-1:0] flag_d = (flag_q & ~clr) | hit;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dir_q  <= '0;
            out_q  <= '0;
            flag_q <= '0;
            slew_q <= 1'b0;
        end else begin
            dir_q  <= dir_d;
            out_q  <= out_d;
            flag_q <= flag_d;
            slew_q <= reg_slew ? req.wdata[0] : slew_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-pin control and sensing
    for (genvar i = 0; i < N; i++) begin : g_pin
        wire [4:0] pc_addr = gpg_pkg::OFF_PIN_CTRL + 5'(i);
        wire       pc_wr   = req.wr && (req.addr == pc_addr);
        gpg_pkg::gpg_pin_ctrl_t pc;

        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                pctl_q[i] <= gpg_pkg::RESET_BYTE;
            end else if (pc_wr) begin
                pctl_q[i] <= req.wdata & gpg_pkg::PC_MASK;
            end
        end

        assign pc        = pctl_q[i];
        assign inv[i]    = pc.inv;
        assign buf_on[i] = (pc.sense != 3'(gpg_pkg::SENSE_NOBUF));
        assign irq_en[i] = (pc.sense != 3'(gpg_pkg::SENSE_OFF)) && buf_on[i];

        // inverted pin level seen by sensing: flipping polarity makes an edge
        wire lvl_in = pin_i[i] ^ inv[i];

        gpg_pin_sense u_sense (
            .ref_clk (ref_clk),
            .rst     (rst),
            .pin_lvl (lvl_in),
            .buf_en  (buf_on[i]),
            .sense   (pc.sense),
            .level   (lvl[i]),
            .hit     (hit[i])
        );

        // output path, with override
        wire gp_oe = dir_q[i];
        wire gp_o  = out_q[i] ^ inv[i];
        assign pin_oe[i]     = ovr_en[i] ? ovr_oe[i] : gp_oe;
        assign pin_o[i]      = ovr_en[i] ? (ovr_o[i] ^ inv[i]) : gp_o;
        assign pin_pull[i]   = pc.pull & ~pin_oe[i];
        assign pin_buf_en[i] = buf_on[i];
        assign pin_event[i]  = buf_on[i] & lvl_in;
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt and asynchronous wake
    assign irq        = |(flag_q & irq_en);
    assign slew_limit = slew_q;

    // wake from raw pin levels, no clock needed
    logic [N-1:0] wake_pin;
    always_comb begin
        for (int k = 0; k < N; k++) begin
            case (gpg_pkg::gpg_sense_t'(pctl_q[k][2:0]))
                gpg_pkg::SENSE_BOTH,
                gpg_pkg::SENSE_RISE,
                gpg_pkg::SENSE_FALL: wake_pin[k] = lvl[k] != (pin_i[k] ^ inv[k]);
                gpg_pkg::SENSE_LOW:  wake_pin[k] = ~(pin_i[k] ^ inv[k]);
                default:             wake_pin[k] = 1'b0;
            endcase
        end
    end
    assign wake = |wake_pin | irq;

    ////////////////////////////////////////////////////////////////////////////
    // read decode
    wire [7:0] dir_b  = 8'(dir_q);
    wire [7:0] out_b  = 8'(out_q);
    wire [7:0] lvl_b  = 8'(lvl);
    wire [7:0] flag_b = 8'(flag_q);
    wire [2:0] pc_idx = req.addr[2:0];
    wire       pc_hit = (req.addr[4:3] == gpg_pkg::OFF_PIN_CTRL[4:3])
                        && (32'(pc_idx) < N);

    always_comb begin
        rdata = 8'h00;
        if (req.rd) begin
            if (pc_hit) begin
                rdata = pctl_q[pc_idx];
            end else if (req.addr <= gpg_pkg::OFF_DIR_TGL) begin
                rdata = dir_b;
            end else if (req.addr <= gpg_pkg::OFF_OUT_TGL) begin
                rdata = out_b;
            end else begin
                case (req.addr)
                    gpg_pkg::OFF_LEVEL:    rdata = lvl_b;
                    gpg_pkg::OFF_FLAGS:    rdata = flag_b;
                    gpg_pkg::OFF_GRP_CTRL: rdata = {7'h00, slew_q};
                    default:               rdata = 8'h00;
                endcase
            end
        end
    end

    always_comb begin
        fa_rdata = 8'h00;
        if (fa_rd) begin
            case (fa_addr)
                gpg_pkg::FA_DIR:   fa_rdata = dir_b;
                gpg_pkg::FA_OUT:   fa_rdata = out_b;
                gpg_pkg::FA_LEVEL: fa_rdata = lvl_b;
                gpg_pkg::FA_FLAGS: fa_rdata = flag_b;
                default:           fa_rdata = 8'h00;
            endcase
        end
    end
endmodule

/* File: test/gpg_port_group_checker.sv */
// Purpose: port-level assertions for the port group
// Assumes: one clock domain, async active-high reset
// Notes:   bound to every gpg_port_group instance
`timescale 1ns/1ps
module gpg_port_group_checker #(
    parameter int unsigned N = 8
) (
    // clock and reset
    input wire logic              ref_clk,
    input wire logic              rst,
    // register side
    input wire gpg_pkg::gpg_req_t req,
    input wire logic              fa_wr,
    input wire logic [N-1:0]      ovr_en,
    // pin side
    input wire logic [N-1:0]      pin_oe,
    input wire logic [N-1:0]      pin_pull,
    input wire logic [N-1:0]      pin_buf_en,
    input wire logic [N-1:0]      pin_event,
    input wire logic              slew_limit,
    input wire logic              irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // lone register write with no override, then one settled cycle
    sequence wr_at(logic [4:0] a);
        req.wr && req.addr == a && !fa_wr && ovr_en == '0 ##1 ovr_en == '0;
    endsequence
    chk_reset_safe: assert property (disable iff (1'b0) rst |->
        pin_oe == '0 && pin_buf_en == '1) else $error("drive or buffer wrong in reset");
    chk_pull_input: assert property ((pin_pull & pin_oe) == '0)
        else $error("pull-up on a driven pin");
    chk_event_gated: assert property ((pin_event & ~pin_buf_en) == '0)
        else $error("event with buffer off");
    chk_dir_set: assert property (wr_at(gpg_pkg::OFF_DIR_SET) |->
        (pin_oe & $past(req.wdata[N-1:0])) == $past(req.wdata[N-1:0]))
        else $error("direction set missed");
    chk_dir_clr: assert property (wr_at(gpg_pkg::OFF_DIR_CLR) |->
        (pin_oe & $past(req.wdata[N-1:0])) == '0) else $error("direction clear missed");
    chk_dir_tgl: assert property (wr_at(gpg_pkg::OFF_DIR_TGL) |->
        pin_oe == ($past(pin_oe) ^ $past(req.wdata[N-1:0])))
        else $error("direction toggle wrong");
    chk_slew_follow: assert property (req.wr && req.addr == gpg_pkg::OFF_GRP_CTRL |=>
        slew_limit == $past(req.wdata[0])) else $error("slew bit not applied");
    chk_irq_holds: assert property (irq && !req.wr && !fa_wr |=> irq)
        else $error("request dropped without a write");
    chk_buf_steady: assert property (!req.wr && !fa_wr |=> $stable(pin_buf_en))
        else $error("buffer enable moved without a write");
endmodule
bind gpg_port_group gpg_port_group_checker #(.N(N)) u_gpg_port_group_checker (
    .ref_clk(ref_clk), .rst(rst), .req(req), .fa_wr(fa_wr), .ovr_en(ovr_en),
    .pin_oe(pin_oe), .pin_pull(pin_pull), .pin_buf_en(pin_buf_en),
    .pin_event(pin_event), .slew_limit(slew_limit), .irq(irq)
);

/* File: test/gpg_pin_model.sv */
// Purpose: board circuit on the far side of the pins
// Assumes: a board source per pin that may be switched off
// Notes:   an undriven pin with no pull-up drifts away from the last drive
`timescale 1ns/1ps
module gpg_pin_model #(
    parameter int unsigned N = 8
) (
    // design side
    input wire logic [N-1:0] pin_o,
    input wire logic [N-1:0] pin_oe,
    input wire logic [N-1:0] pin_pull,
    // board side
    input wire logic [N-1:0] ext_lvl,
    input wire logic [N-1:0] ext_en,
    output logic [N-1:0]     pin_i
);
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_lvl)
                 | (~pin_oe & ~ext_en & (pin_pull | ~pin_o));
endmodule

/* File: test/gpg_port_group_tb.sv */
// Purpose: self-checking bench for the port group
// Assumes: inputs change on the falling edge, 100 ns clock
// Notes:   model keeps direction and drive bytes beside the design
`timescale 1ns/1ps
module gpg_port_group_tb;
    logic              ref_clk = 1'b0;
    logic              rst = 1'b1;
    gpg_pkg::gpg_req_t req = '0;
    logic              fa_wr = 1'b0;
    logic              fa_rd = 1'b0;
    logic [1:0]        fa_addr = 2'h0;
    logic [7:0]        fa_wdata = 8'h00;
    logic [7:0]        ovr_en = 8'h00;
    logic [7:0]        ovr_oe = 8'h00;
    logic [7:0]        ovr_o = 8'h00;
    logic [7:0]        ext_lvl = 8'h00;
    logic [7:0]        rdata, fa_rdata, pin_i, pin_o, pin_oe, pin_pull, pin_buf_en, pin_event;
    logic              slew_limit, irq, wake;
    logic [7:0]        m_dir, m_drv, d, f;
    int                fails = 0;
    int                n_tests = 0;
    int                op, seed_v;
    logic [4:0]        addr_tab [7] = '{gpg_pkg::OFF_DIR_SET, gpg_pkg::OFF_DIR_CLR,
        gpg_pkg::OFF_DIR_TGL, gpg_pkg::OFF_OUT_SET, gpg_pkg::OFF_OUT_CLR,
        gpg_pkg::OFF_OUT_TGL, gpg_pkg::OFF_LEVEL};
    always #50 ref_clk = ~ref_clk;
    gpg_port_group u_gpg_port_group (.ref_clk(ref_clk), .rst(rst), .req(req), .rdata(rdata),
        .fa_wr(fa_wr), .fa_rd(fa_rd), .fa_addr(fa_addr), .fa_wdata(fa_wdata),
        .fa_rdata(fa_rdata), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
        .pin_pull(pin_pull), .pin_buf_en(pin_buf_en), .slew_limit(slew_limit),
        .ovr_en(ovr_en), .ovr_oe(ovr_oe), .ovr_o(ovr_o), .pin_event(pin_event),
        .irq(irq), .wake(wake));
    gpg_pin_model u_gpg_pin_model (.pin_o(pin_o), .pin_oe(pin_oe), .pin_pull(pin_pull),
        .ext_lvl(ext_lvl), .ext_en(8'hff), .pin_i(pin_i));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] dv);
        @(negedge ref_clk);
        req.rd = 1'b0;
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = dv;
        @(negedge ref_clk);
        req.wr = 1'b0;
    endtask
    task automatic rchk(input logic [4:0] a, input logic [7:0] exp, input string what);
        @(negedge ref_clk);
        req.rd = 1'b1;
        req.addr = a;
        #10;
        check(what, rdata, exp);
    endtask
    task automatic fa_acc(input logic w, input logic [1:0] a, input logic [7:0] dv);
        @(negedge ref_clk);
        fa_wr = w;
        fa_rd = !w;
        fa_addr = a;
        fa_wdata = dv;
        @(negedge ref_clk);
        fa_wr = 1'b0;
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #5000000;
        fails++;
        report_and_stop();
    end
    initial begin
        seed_v = $urandom(91);
        ext_lvl = 8'($urandom);
        m_dir = 8'h00;
        m_drv = 8'h00;
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        check("oe_reset", pin_oe, 8'h00);
        check("buf_reset", pin_buf_en, 8'hff);
        rchk(gpg_pkg::OFF_DIR, 8'h00, "dir_reset");
        // random set, clear, toggle and alias writes against the model
        for (int i = 0; i < 40; i++) begin
            op = $urandom % 9;
            d = 8'($urandom);
            case (op)
                0: m_dir = m_dir | d;
                1: m_dir = m_dir & ~d;
                2: m_dir = m_dir ^ d;
                3: m_drv = m_drv | d;
                4: m_drv = m_drv & ~d;
                5, 6: m_drv = m_drv ^ d;
                7: m_dir = d;
                default: m_drv = d;
            endcase
            if (op < 7) wr(addr_tab[op], d);
            else fa_acc(1'b1, 2'(op - 7), d);
            rchk(gpg_pkg::OFF_DIR, m_dir, "dir");
            rchk(gpg_pkg::OFF_OUT, m_drv, "drive");
            check("oe", pin_oe, m_dir);
            check("pin_out", pin_o, m_drv);
            repeat (3) @(negedge ref_clk);
            rchk(gpg_pkg::OFF_LEVEL, (m_dir & m_drv) | (~m_dir & ext_lvl), "level");
            fa_acc(1'b0, gpg_pkg::FA_DIR, 8'h00);
            check("fa_dir", fa_rdata, m_dir);
        end
        // every sense setting on pin 0, pin as input
        wr(gpg_pkg::OFF_DIR, 8'h00);
        m_dir = 8'h00;
        for (int s = 0; s < 6; s++) begin
            ext_lvl[0] = 1'b1;
            wr(gpg_pkg::OFF_PIN_CTRL, 8'(s));
            repeat (5) @(negedge ref_clk);
            wr(gpg_pkg::OFF_FLAGS, 8'hff);
            check("buf_en", {7'h0, pin_buf_en[0]}, {7'h0, s != 4});
            ext_lvl[0] = 1'b0;
            repeat (5) @(negedge ref_clk);
            f = {7'h0, s == 1 || s == 3 || s == 5};
            rchk(gpg_pkg::OFF_FLAGS, f, "flag_fall");
            check("irq_fall", {7'h0, irq}, f);
            check("wake", {7'h0, wake}, f);
            rchk(gpg_pkg::OFF_LEVEL, {ext_lvl[7:1], s == 4}, "level_frozen");
            check("event", {7'h0, pin_event[0]}, 8'h00);
            wr(gpg_pkg::OFF_FLAGS, 8'h00);
            rchk(gpg_pkg::OFF_FLAGS, f, "flag_keep");
            if (s != 5) begin
                wr(gpg_pkg::OFF_FLAGS, 8'hff);
                ext_lvl[0] = 1'b1;
                repeat (5) @(negedge ref_clk);
                rchk(gpg_pkg::OFF_FLAGS, {7'h0, s == 1 || s == 2}, "flag_rise");
                check("event_hi", {7'h0, pin_event[0]}, {7'h0, s != 4});
            end
        end
        // inversion on pin 0 with both edges sensed
        wr(gpg_pkg::OFF_PIN_CTRL, 8'h01);
        repeat (5) @(negedge ref_clk);
        wr(gpg_pkg::OFF_FLAGS, 8'hff);
        // same sense setting, only inversion and reserved bits change
        wr(gpg_pkg::OFF_PIN_CTRL, 8'hf1);
        repeat (5) @(negedge ref_clk);
        rchk(gpg_pkg::OFF_FLAGS, 8'h01, "inv_edge");
        rchk(gpg_pkg::OFF_LEVEL, ((m_dir & m_drv) | (~m_dir & ext_lvl)) ^ 8'h01,
             "inv_level");
        rchk(gpg_pkg::OFF_PIN_CTRL, gpg_pkg::PC_MASK & 8'hf1, "pin_ctrl");
        check("inv_out", {7'h0, pin_o[0]}, {7'h0, ~m_drv[0]});
        // override on pin 0 only
        @(negedge ref_clk);
        ovr_en = 8'h01;
        ovr_oe = 8'h01;
        ovr_o = 8'h01;
        #10;
        check("ovr_oe", pin_oe, 8'h01);
        check("ovr_o", {7'h0, pin_o[0]}, 8'h00);
        @(negedge ref_clk);
        ovr_en = 8'h00;
        // pull-up on pin 1, slew, unmapped offset
        wr(gpg_pkg::OFF_PIN_CTRL + 5'h01, 8'h08);
        check("pull_in", pin_pull & 8'h02, 8'h02);
        wr(gpg_pkg::OFF_DIR_SET, 8'h02);
        check("pull_out", pin_pull & 8'h02, 8'h00);
        wr(gpg_pkg::OFF_GRP_CTRL, 8'h01);
        check("slew", {7'h0, slew_limit}, 8'h01);
        rchk(5'h0c, 8'h00, "unmapped");
        report_and_stop();
    end
endmodule
